// ==== logic/tsc_consts.svh ====
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// Handshake pattern defaults
`define TSC_PAT_W 8
`define TSC_PAT_A 8'h12
`define TSC_PAT_B 8'h9a
`define TSC_PAT_IDLE 8'h00

// Packet fields
`define TSC_DATA_W 32
`define TSC_KIND_W 2
`define TSC_BAR_W 3
`define TSC_TAG_W 8
`define TSC_KIND_MRD 2'h0
`define TSC_KIND_MWR 2'h1
`define TSC_KIND_VDM 2'h2
`define TSC_KIND_OTHER 2'h3
`define TSC_BITSTREAM_BAR 3'h6
`define TSC_CPL_DATA 32'h0000_0000

// Critical core input count
`define TSC_CRIT_W 4
`define TSC_CRIT_OFF 4'h0

`endif

// ==== logic/tsc_first_stage.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

// Summary of operation
// - Stage-ready driven out once first stage ready
// - Second stage drives stage-ready; derives live
// - Live only after second stage loaded
// - Generator alternates two pattern values each cycle
// - Pattern registered on core clock
// - Both pattern values are parameters
// - Pattern starts only after start-up command
// - Pattern detected: assert ready, live, hand over
// - Critical inputs held deasserted until live
// - Critical inputs pass through once live
// - Consumer drains packets the core ignores
// - Reads answered with all-zero one-word completion
// - Vendor messages purged, nothing else done
// - Aperture writes forwarded to configuration port
// - Host sends image as one-word writes
// - Consumer inactive once second stage live
// - Done asserts after first stage loads
// - User never resets core after second stage
// - Image is whole 32-bit words
// - Done pulses at stage one, holds at two
module tsc_first_stage import tsc_pkg::*; #(
	parameter int CRIT_W = `TSC_CRIT_W,
	parameter logic [`TSC_PAT_W-1:0] PAT_A = `TSC_PAT_A,
	parameter logic [`TSC_PAT_W-1:0] PAT_B = `TSC_PAT_B,
	parameter logic [`TSC_BAR_W-1:0] APERTURE_BAR = `TSC_BITSTREAM_BAR
) (
	input wire logic core_clk,
	input wire logic rstn,
	tsc_link_if.dev link,
	input wire logic stage1_loaded,
	input wire logic [CRIT_W-1:0] crit_in,
	output logic [CRIT_W-1:0] crit_core,
	output logic cfg_wr_valid,
	output logic [`TSC_DATA_W-1:0] cfg_wr_data,
	output logic done,
	output logic icap_rdy,
	output logic usr_rx_valid,
	input wire logic usr_rx_ready,
	output logic [`TSC_KIND_W-1:0] usr_rx_kind,
	output logic [`TSC_BAR_W-1:0] usr_rx_bar,
	output logic [`TSC_TAG_W-1:0] usr_rx_tag,
	output logic [`TSC_DATA_W-1:0] usr_rx_data
);

	// ****************************************
	// Stage sequencing
	// ****************************************

	tsc_stage_type stage;
	tsc_stage_type next_stage;
	logic found;
	logic live;
	logic loading;

	assign live = (stage == TSC_ST_LIVE);
	assign loading = (stage == TSC_ST_LOAD);

	// Pattern search runs only while the second stage is loading
	tsc_pattern_checker #(
		.PAT_W(`TSC_PAT_W),
		.PAT_A(PAT_A),
		.PAT_B(PAT_B)
	) u_checker (
		.core_clk(core_clk),
		.rstn(rstn),
		.arm(loading),
		.sample(link.pattern),
		.found(found)
	);

	// Next stage: first -> load on stage1_loaded, load -> live on detection
	always_comb begin
		next_stage = stage;
		case (stage)
			TSC_ST_FIRST: begin
				if (stage1_loaded) begin
					next_stage = TSC_ST_LOAD;
				end
			end
			TSC_ST_LOAD: begin
				if (found) begin
					next_stage = TSC_ST_LIVE;
				end
			end
			TSC_ST_LIVE: begin
				next_stage = TSC_ST_LIVE;
			end
			default: begin
				next_stage = TSC_ST_FIRST;
			end
		endcase
	end

	// Live is final: nothing short of a full reset returns to stage one
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			stage <= TSC_ST_FIRST;
		end else begin
			stage <= next_stage;
		end
	end

	// ****************************************
	// Handshake outputs
	// ****************************************

	// Drive stage-ready from load onward; in live both ends hold it high
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			link.rdy_dev_o <= 1'b0;
			link.rdy_dev_oe <= 1'b0;
		end else begin
			link.rdy_dev_o <= (next_stage != TSC_ST_FIRST);
			link.rdy_dev_oe <= (next_stage != TSC_ST_FIRST);
		end
	end

	// Live flag follows the wire the second stage now also drives
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			icap_rdy <= 1'b0;
		end else begin
			icap_rdy <= live && link.rdy;
		end
	end

	// Done: one-cycle pulse entering load, steady high once live
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			done <= 1'b0;
		end else if (next_stage == TSC_ST_LIVE) begin
			done <= 1'b1;
		end else begin
			done <= (stage == TSC_ST_FIRST) && stage1_loaded;
		end
	end

	// ****************************************
	// Critical input masking
	// ****************************************

	// Glitches from half-loaded logic never reach the core
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			crit_core <= CRIT_W'(`TSC_CRIT_OFF);
		end else if (icap_rdy) begin
			crit_core <= crit_in;
		end else begin
			crit_core <= CRIT_W'(`TSC_CRIT_OFF);
		end
	end

	// ****************************************
	// Packet consumer
	// ****************************************

	tsc_cons_type cstate;
	logic take;
	logic is_wr_hit;

	// Consumer accepts only while loading; live hands packets to the user
	assign take = link.rx_valid && link.rx_ready && !live;
	assign is_wr_hit = (link.rx_kind == `TSC_KIND_MWR) && (link.rx_bar == APERTURE_BAR);

	always_comb begin
		if (live) begin
			link.rx_ready = usr_rx_ready;
		end else begin
			link.rx_ready = loading && (cstate == TSC_C_IDLE);
		end
	end

	// Pass-through toward the user design once live
	assign usr_rx_valid = live && link.rx_valid;
	assign usr_rx_kind = link.rx_kind;
	assign usr_rx_bar = link.rx_bar;
	assign usr_rx_tag = link.rx_tag;
	assign usr_rx_data = link.rx_data;

	// A read holds the consumer until its completion is taken
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cstate <= TSC_C_IDLE;
		end else begin
			case (cstate)
				TSC_C_IDLE: begin
					if (take && link.rx_kind == `TSC_KIND_MRD) begin
						cstate <= TSC_C_CPL;
					end
				end
				TSC_C_CPL: begin
					if (link.cpl_ready) begin
						cstate <= TSC_C_IDLE;
					end
				end
				default: begin
					cstate <= TSC_C_IDLE;
				end
			endcase
		end
	end

	// Completion: requester's tag, payload always zero
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			link.cpl_tag <= '0;
			link.cpl_data <= `TSC_CPL_DATA;
		end else if (take && link.rx_kind == `TSC_KIND_MRD) begin
			link.cpl_tag <= link.rx_tag;
			link.cpl_data <= `TSC_CPL_DATA;
		end
	end

	assign link.cpl_valid = (cstate == TSC_C_CPL);

	// Aperture writes become configuration words; all else is dropped
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cfg_wr_valid <= 1'b0;
		end else begin
			cfg_wr_valid <= take && is_wr_hit;
		end
	end

	// Data only loads on a hit, so stray writes leave the port untouched
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cfg_wr_data <= '0;
		end else if (take && is_wr_hit) begin
			cfg_wr_data <= link.rx_data;
		end
	end

endmodule : tsc_first_stage

// ==== logic/tsc_link_if.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

interface tsc_link_if (
	input wire logic core_clk
);
	import tsc_pkg::*;

	// Request packets toward the first stage
	logic rx_valid;
	logic rx_ready;
	tsc_kind_type rx_kind;
	logic [`TSC_BAR_W-1:0] rx_bar;
	logic [`TSC_TAG_W-1:0] rx_tag;
	logic [`TSC_DATA_W-1:0] rx_data;
	// Completions back to the requester
	logic cpl_valid;
	logic cpl_ready;
	logic [`TSC_TAG_W-1:0] cpl_tag;
	logic [`TSC_DATA_W-1:0] cpl_data;
	// Handshake pattern from the second stage
	logic [`TSC_PAT_W-1:0] pattern;
	// Stage-ready wire, driven by either end
	logic rdy_dev_o;
	logic rdy_dev_oe;
	logic rdy_usr_o;
	logic rdy_usr_oe;
	logic rdy;

	// Wired-OR resolution; undriven wire reads low
	assign rdy = (rdy_dev_oe & rdy_dev_o) | (rdy_usr_oe & rdy_usr_o);

	modport dev (
		input rx_valid, rx_kind, rx_bar, rx_tag, rx_data, cpl_ready, pattern, rdy,
		output rx_ready, cpl_valid, cpl_tag, cpl_data, rdy_dev_o, rdy_dev_oe
	);

	modport usr (
		input rx_ready, cpl_valid, cpl_tag, cpl_data, rdy,
		output rx_valid, rx_kind, rx_bar, rx_tag, rx_data, cpl_ready, pattern,
		output rdy_usr_o, rdy_usr_oe
	);

endinterface : tsc_link_if

// ==== logic/tsc_pattern_checker.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

module tsc_pattern_checker import tsc_pkg::*; #(
	parameter int PAT_W = `TSC_PAT_W,
	parameter logic [PAT_W-1:0] PAT_A = `TSC_PAT_A,
	parameter logic [PAT_W-1:0] PAT_B = `TSC_PAT_B
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic arm,
	input wire logic [PAT_W-1:0] sample,
	output logic found
);

	logic prev_a;
	logic prev_b;
	logic hit_a;
	logic hit_b;

	assign hit_a = (sample == PAT_A);
	assign hit_b = (sample == PAT_B);

	// Remember last sample's match; any other value restarts the search
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else begin
			prev_a <= hit_a;
			prev_b <= hit_b;
		end
	end

	// Sticky once a full alternation pair is seen while armed
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			found <= 1'b0;
		end else if (arm && ((prev_a && hit_b) || (prev_b && hit_a))) begin
			found <= 1'b1;
		end
	end

endmodule : tsc_pattern_checker

// ==== logic/tsc_pkg.sv ====
`include "tsc_consts.svh"

package tsc_pkg;

	// Stage progress, Gray along first -> load -> live
	typedef enum logic [1:0] {
		TSC_ST_FIRST = 2'h0,
		TSC_ST_LOAD = 2'h1,
		TSC_ST_LIVE = 2'h3
	} tsc_stage_type;

	// Packet consumer state
	typedef enum logic {
		TSC_C_IDLE = 1'h0,
		TSC_C_CPL = 1'h1
	} tsc_cons_type;

	typedef logic [`TSC_KIND_W-1:0] tsc_kind_type;

endpackage : tsc_pkg

// ==== logic/tsc_second_stage.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

module tsc_second_stage import tsc_pkg::*; #(
	parameter logic [`TSC_PAT_W-1:0] PAT_A = `TSC_PAT_A,
	parameter logic [`TSC_PAT_W-1:0] PAT_B = `TSC_PAT_B
) (
	input wire logic core_clk,
	input wire logic rstn,
	tsc_link_if.usr link,
	input wire logic startup_done,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [`TSC_KIND_W-1:0] req_kind,
	input wire logic [`TSC_BAR_W-1:0] req_bar,
	input wire logic [`TSC_TAG_W-1:0] req_tag,
	input wire logic [`TSC_DATA_W-1:0] req_data,
	output logic cpl_seen,
	output logic [`TSC_TAG_W-1:0] cpl_tag_out,
	output logic [`TSC_DATA_W-1:0] cpl_data_out
);

	// ****************************************
	// Handshake generator
	// ****************************************

	logic started;
	logic [`TSC_PAT_W-1:0] pat;

	// Latched start-up; core reset is never issued from here
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			started <= 1'b0;
		end else if (startup_done) begin
			started <= 1'b1;
		end
	end

	// Alternate every cycle once started, registered on the core clock
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			pat <= `TSC_PAT_IDLE;
		end else if (!started) begin
			pat <= `TSC_PAT_IDLE;
		end else if (pat == PAT_A) begin
			pat <= PAT_B;
		end else begin
			pat <= PAT_A;
		end
	end

	assign link.pattern = pat;
	assign link.rdy_usr_o = 1'b1;
	assign link.rdy_usr_oe = started;

	// ****************************************
	// Request and completion ports
	// ****************************************

	// One-deep slot: refill when empty or being taken
	assign req_ready = !link.rx_valid || link.rx_ready;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			link.rx_valid <= 1'b0;
		end else if (req_ready) begin
			link.rx_valid <= req_valid;
		end
	end

	// Each request carries exactly one 32-bit word
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			link.rx_kind <= `TSC_KIND_OTHER;
			link.rx_bar <= '0;
			link.rx_tag <= '0;
			link.rx_data <= '0;
		end else if (req_ready && req_valid) begin
			link.rx_kind <= req_kind;
			link.rx_bar <= req_bar;
			link.rx_tag <= req_tag;
			link.rx_data <= req_data;
		end
	end

	// Completions always accepted and reported for one cycle
	assign link.cpl_ready = 1'b1;

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			cpl_seen <= 1'b0;
			cpl_tag_out <= '0;
			cpl_data_out <= '0;
		end else begin
			cpl_seen <= link.cpl_valid;
			if (link.cpl_valid) begin
				cpl_tag_out <= link.cpl_tag;
				cpl_data_out <= link.cpl_data;
			end
		end
	end

endmodule : tsc_second_stage

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %h got %h", nm, (e), (g)); end end

// ********
// Bench
// ********
module tb_top;
	logic core_clk = 0, rstn = 0, stage1_loaded = 0, startup_done = 0;
	logic [3:0] crit_in = 4'h0, crit_core;
	logic cfg_wr_valid, done, icap_rdy, usr_rx_valid, cpl_seen, req_ready;
	logic [31:0] cfg_wr_data, usr_rx_data, cpl_data_out, d;
	logic [7:0] cpl_tag_out, i, usr_rx_tag;
	logic [1:0] usr_rx_kind;
	logic [2:0] usr_rx_bar;
	logic req_valid = 0;
	logic [1:0] req_kind = 2'h3;
	logic [2:0] req_bar = 3'h0, b;
	logic [7:0] req_tag = 8'h00;
	logic [31:0] req_data = 32'h0;
	int fail_count = 0, num_checks = 0, seed = 46960, n;
	logic [31:0] q_cfg[$];
	logic [44:0] q_usr[$];
	logic [39:0] q_cpl[$];

	// 200 MHz
	always #2.5 core_clk = ~core_clk;

	tsc_link_if link (.core_clk(core_clk));
	tsc_first_stage u_tsc_first_stage (.core_clk(core_clk), .rstn(rstn), .link(link),
		.stage1_loaded(stage1_loaded), .crit_in(crit_in), .crit_core(crit_core),
		.cfg_wr_valid(cfg_wr_valid), .cfg_wr_data(cfg_wr_data), .done(done),
		.icap_rdy(icap_rdy), .usr_rx_valid(usr_rx_valid), .usr_rx_ready(1'b1),
		.usr_rx_kind(usr_rx_kind), .usr_rx_bar(usr_rx_bar), .usr_rx_tag(usr_rx_tag),
		.usr_rx_data(usr_rx_data));
	tsc_second_stage u_tsc_second_stage (.core_clk(core_clk), .rstn(rstn), .link(link),
		.startup_done(startup_done), .req_valid(req_valid), .req_ready(req_ready),
		.req_kind(req_kind), .req_bar(req_bar), .req_tag(req_tag), .req_data(req_data),
		.cpl_seen(cpl_seen), .cpl_tag_out(cpl_tag_out), .cpl_data_out(cpl_data_out));
	tsc_assertions u_tsc_assertions (.core_clk(core_clk), .rstn(rstn),
		.rx_valid(link.rx_valid), .rx_ready(link.rx_ready), .rx_kind(link.rx_kind),
		.rx_tag(link.rx_tag), .cpl_valid(link.cpl_valid), .cpl_ready(link.cpl_ready),
		.cpl_tag(link.cpl_tag), .cpl_data(link.cpl_data), .pattern(link.pattern),
		.rdy(link.rdy));

	task results;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// Request held until the handshake takes it; valid stays up for back to back use
	task automatic req(input logic [1:0] k, input logic [2:0] bb, input logic [7:0] t,
		input logic [31:0] dd);
		int m;
		req_valid = 1;
		req_kind = k;
		req_bar = bb;
		req_tag = t;
		req_data = dd;
		for (m = 0; m < 20; m++) begin
			#1;
			if (req_ready === 1'b1) break;
			@(negedge core_clk);
		end
		if (m == 20) begin fail_count++; results(); end
		@(negedge core_clk);
	endtask : req

	// Results taken off the notes in order; a result with no note expects unknown
	always @(negedge core_clk) begin
		logic [44:0] e;
		if (cfg_wr_valid) begin
			e = q_cfg.size() ? q_cfg.pop_front() : 'x;
			`CHK("cfg data", e[31:0], cfg_wr_data)
		end
		if (cpl_seen) begin
			e = q_cpl.size() ? q_cpl.pop_front() : 'x;
			`CHK("completion", e[39:0], {cpl_tag_out, cpl_data_out})
		end
		if (usr_rx_valid) begin
			e = q_usr.size() ? q_usr.pop_front() : 'x;
			`CHK("user data", e, {usr_rx_kind, usr_rx_bar, usr_rx_tag, usr_rx_data})
		end
	end

	// Main sequence
	initial begin
		repeat (6) @(negedge core_clk);
		rstn = 1;
		d = $random(seed);
		// Never zero, so a stuck mask cannot pass the pass-through check
		crit_in = d[3:0] | 4'h1;
		@(negedge core_clk);
		`CHK("crit masked", 4'h0, crit_core)
		stage1_loaded = 1;
		@(negedge core_clk);
		`CHK("done pulse", 1'b1, done)
		@(negedge core_clk);
		`CHK("done pulse end", 1'b0, done)
		// Aperture writes back to back
		for (i = 0; i < 4; i++) begin
			d = $random(seed);
			q_cfg.push_back(d);
			req(`TSC_KIND_MWR, `TSC_BITSTREAM_BAR, i, d);
		end
		// Every kind twice; writes miss the aperture and must vanish
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			b = (d[2:0] == `TSC_BITSTREAM_BAR) ? 3'h0 : d[2:0];
			if (i[2:1] == `TSC_KIND_MRD) q_cpl.push_back({i, `TSC_CPL_DATA});
			req(i[2:1], b, i, d);
		end
		req_valid = 0;
		repeat (3) @(negedge core_clk);
		`CHK("not live yet", 1'b0, icap_rdy)
		`CHK("crit still masked", 4'h0, crit_core)
		startup_done = 1;
		for (n = 0; n < 40 && icap_rdy !== 1'b1; n++) @(negedge core_clk);
		if (n == 40) begin fail_count++; results(); end
		`CHK("done held", 1'b1, done)
		@(negedge core_clk);
		`CHK("crit passes", crit_in, crit_core)
		// Once live, aperture writes reach the user side only
		d = $random(seed);
		q_usr.push_back({`TSC_KIND_MWR, `TSC_BITSTREAM_BAR, 8'h20, d});
		req(`TSC_KIND_MWR, `TSC_BITSTREAM_BAR, 8'h20, d);
		req_valid = 0;
		repeat (6) @(negedge core_clk);
		`CHK("notes left", 0, q_cfg.size() + q_cpl.size() + q_usr.size())
		results();
	end
endmodule : tb_top

// ==== sim/tsc_assertions.sv ====
`timescale 1ns/100ps
`include "tsc_consts.svh"

// ********
// Link checker
// ********
module tsc_assertions import tsc_pkg::*; #(
	parameter logic [`TSC_PAT_W-1:0] PAT_A = `TSC_PAT_A,
	parameter logic [`TSC_PAT_W-1:0] PAT_B = `TSC_PAT_B
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire tsc_kind_type rx_kind,
	input wire logic [`TSC_TAG_W-1:0] rx_tag,
	input wire logic cpl_valid,
	input wire logic cpl_ready,
	input wire logic [`TSC_TAG_W-1:0] cpl_tag,
	input wire logic [`TSC_DATA_W-1:0] cpl_data,
	input wire logic [`TSC_PAT_W-1:0] pattern,
	input wire logic rdy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Accepted request on the link
	logic take;
	assign take = rx_valid && rx_ready;

	sequence s_read;
		take && rx_kind == `TSC_KIND_MRD;
	endsequence

	// Three steps of the alternating pattern
	sequence s_alt;
		pattern == PAT_A ##1 pattern == PAT_B ##1 pattern == PAT_A;
	endsequence

	chk_read_answer: assert property (s_read |=> cpl_valid && cpl_tag == $past(rx_tag))
		else $error("read not answered with its tag");
	chk_cpl_zero: assert property (cpl_valid |-> cpl_data == `TSC_CPL_DATA)
		else $error("completion payload not zero");
	chk_cpl_once: assert property (cpl_valid && cpl_ready |=> !cpl_valid)
		else $error("completion repeated");
	chk_cpl_stall: assert property (cpl_valid |-> !rx_ready)
		else $error("request taken during completion");
	chk_no_reply: assert property (take && rx_kind != `TSC_KIND_MRD |=> !cpl_valid)
		else $error("completion for non-read");
	chk_first_stall: assert property (!rdy |-> !rx_ready)
		else $error("request taken before ready");
	chk_rdy_stays: assert property (rdy |=> rdy)
		else $error("ready dropped");
	chk_pat_alt: assert property (pattern == PAT_A |-> s_alt)
		else $error("pattern not alternating");
endmodule : tsc_assertions
